// ### verilog/pmw_power_ctrl.sv
// Power-mode and wake-up controller: idle, stop and sleep entry, wake-up
// sequencing with oscillator settle and pll lock waits, reset scoping.
// Assumes ref_clk is the crystal reference clock and all inputs are
// synchronous to it; registers are reached over Avalon-MM.
//
// Summary of operation
// - Interrupt wake from stop or sleep switches the plls back on by itself.
// - Sleep wake restarts as after power-on, only dram contents and the wait registers are kept.
// - Stop wake resumes the previous working state without reinitialising.
// - Before lock: idle keeps pll clock, stop gives none, sleep gives external.
// - After lock: pll clock after idle or stop, external clock after sleep and from then on until cold reset.
// - In normal mode each peripheral clock follows its own enable bit.
// - Setting idle_request enters idle mode.
// - Setting stop_request enters stop mode.
// - Idle and stop end on any interrupt source, warm or cold reset.
// - Writing 0xA3 to sleep_entry_code enters sleep mode.
// - Coded sleep ends on external lines, alarm, warm or cold reset.
// - Battery-fault sleep ends only on external lines 1..0 or a reset.
// - Low battery fault is forwarded as fast irq, enters sleep, or is ignored.
// - Cold reset initialises every register and state.
// - Cold reset is masked while battery fault is low.
// - Warm and soft reset spare clock generator and power management.
// - Lock count holds usb count 27..16, main count 11..0, both all ones.
// - Pll lock wait lasts the lock count times 16 reference periods.
// - Settle register holds usb count 31..16, main 15..0, each 0x5000.
// - Crystal settle wait lasts the settle count in crystal periods.
// - Hardware inserts settle and lock waits, no core clock meanwhile except the external clock after sleep.
// - Idle and stop bits act on a rising edge, software clears them.
// - Stop or sleep first gets self-refresh acknowledge, then stops clocks.
// - Sleep drives regulator_off_n low, releasing it on wake together with oscillator and plls.
`timescale 1ns/1ps
`default_nettype none

module pmw_power_ctrl
  import pmw_pkg::*;
(
  // Clock and power-on reset
  input  wire logic                     ref_clk,
  input  wire logic                     nrst,
  // Avalon-MM register slave
  input  wire logic [31:0]              avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output var  logic [31:0]              avs_readdata,
  output var  logic                     avs_waitrequest,
  // Reset pins and battery fault
  input  wire logic                     cold_reset_n,
  input  wire logic                     warm_reset_n,
  input  wire logic                     battery_fault_n,
  // Wake-up sources
  input  wire pmw_wake_t                wake_src,
  // SDRAM self-refresh handshake
  output var  logic                     sdram_sr_req,
  input  wire logic                     sdram_sr_ack,
  // Clock tree, peripheral gates, regulator and system reset
  output var  pmw_clk_ctl_t             clk_ctl,
  output var  logic [`PMW_PERIPH_W-1:0] periph_clk_en,
  output var  logic                     regulator_off_n,
  output var  logic                     sys_reset_n,
  output var  logic                     fast_irq
);

  // Registers and state
  logic [31:0]            lock_count_q;
  logic [31:0]            settle_wait_q;
  logic [31:0]            clock_gate_q;
  logic [1:0]             batt_mode_q;
  logic                   soft_rst_q;
  logic                   idle_prev_q;
  logic                   stop_prev_q;
  pmw_state_t             state_q;
  pmw_state_t             state_d;
  logic                   to_sleep_q;
  logic                   batt_sleep_q;
  logic                   from_sleep_q;
  logic                   ext_clk_q;
  logic [1:0]             pll_rdy_q;
  logic [`PMW_CNT_W-1:0]  settle_val [2];
  logic [`PMW_LOCK_W-1:0] lock_val   [2];

  logic        cold_rst;
  logic        bus_req;
  logic        wr_take;
  logic        rd_start;
  logic [31:0] be_mask;
  logic [31:0] wr_lock;
  logic [31:0] wr_settle;
  logic [31:0] wr_gate;
  logic [31:0] wr_pm;
  logic [31:0] rd_mux;
  logic        sleep_code_wr;
  logic        idle_edge;
  logic        stop_edge;
  logic        batt_sleep_ev;
  logic        wake_full;
  logic        wake_sleep;
  logic        wake_batt;
  logic        wake_start;
  logic        pll_off;
  logic        sleep_wake;

  // Cold reset is honoured only while the battery is healthy
  assign cold_rst = !cold_reset_n && battery_fault_n;

  // Bus decode: a request is taken on the edge where waitrequest is low
  assign bus_req  = avs_read || avs_write;
  assign wr_take  = avs_write && !avs_waitrequest;
  assign rd_start = avs_read && avs_waitrequest;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      be_mask[b*8 +: 8] = {8{avs_byteenable[b]}};
    end
  end

  assign wr_lock   = (lock_count_q & ~be_mask) | (avs_writedata & be_mask);
  assign wr_settle = (settle_wait_q & ~be_mask) | (avs_writedata & be_mask);
  assign wr_gate   = (clock_gate_q & ~be_mask) | (avs_writedata & be_mask);
  assign wr_pm     = avs_writedata & be_mask;

  // Only the exact code starts sleep; any other byte is dropped
  assign sleep_code_wr = wr_take && (avs_address == `PMW_ADDR_POWER_MGMT) && avs_byteenable[0]
                         && (avs_writedata[`PMW_PM_CODE_MSB:`PMW_PM_CODE_LSB] == `PMW_SLEEP_CODE);

  // Mode bits act only on their rising edge
  assign idle_edge = clock_gate_q[`PMW_CG_IDLE_BIT] && !idle_prev_q;
  assign stop_edge = clock_gate_q[`PMW_CG_STOP_BIT] && !stop_prev_q;

  assign batt_sleep_ev = (batt_mode_q == PMW_BATT_SLEEP) && !battery_fault_n;

  // Wake source sets per entry kind
  assign wake_full  = (|wake_src.ext_int) || wake_src.alarm_int || wake_src.pen_down_int
                      || wake_src.modem_int || !warm_reset_n || !cold_reset_n;
  assign wake_sleep = (|wake_src.ext_int) || wake_src.alarm_int
                      || !warm_reset_n || !cold_reset_n;
  assign wake_batt  = (|wake_src.ext_int[1:0]) || !warm_reset_n || !cold_reset_n;

  // Counters restart when clocks come back from stop or after power-up
  assign wake_start = ((state_q == PMW_STOP) && wake_full) || (state_q == PMW_PWR_UP);
  assign pll_off    = (state_q == PMW_STOP) || (state_q == PMW_SLEEP);
  assign sleep_wake = (state_q == PMW_SLEEP) && (batt_sleep_q ? wake_batt : wake_sleep);

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      PMW_NORMAL: begin
        if (stop_edge || sleep_code_wr || batt_sleep_ev) begin
          state_d = PMW_SR_WAIT;
        end else if (idle_edge) begin
          state_d = PMW_IDLE;
        end
      end
      PMW_IDLE: begin
        if (wake_full) begin
          state_d = PMW_NORMAL;
        end
      end
      PMW_SR_WAIT: begin
        if (sdram_sr_ack) begin
          state_d = to_sleep_q ? PMW_SLEEP : PMW_STOP;
        end
      end
      PMW_STOP: begin
        if (wake_full) begin
          state_d = PMW_WAKE;
        end
      end
      PMW_SLEEP: begin
        if (sleep_wake) begin
          state_d = PMW_PWR_UP;
        end
      end
      PMW_PWR_UP: begin
        state_d = PMW_WAKE;
      end
      PMW_WAKE: begin
        if (&pll_rdy_q) begin
          state_d = PMW_NORMAL;
        end
      end
      default: begin
        state_d = PMW_NORMAL;
      end
    endcase
    // Cold reset overrides any transition so the registered outputs reinitialise too
    if (cold_rst) begin
      state_d = PMW_NORMAL;
    end
  end

  // Sequencer state and entry bookkeeping
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q      <= PMW_NORMAL;
      to_sleep_q   <= 1'b0;
      batt_sleep_q <= 1'b0;
      from_sleep_q <= 1'b0;
    end else if (cold_rst) begin
      state_q      <= PMW_NORMAL;
      to_sleep_q   <= 1'b0;
      batt_sleep_q <= 1'b0;
      from_sleep_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == PMW_NORMAL && state_d == PMW_SR_WAIT) begin
        to_sleep_q   <= !stop_edge;
        batt_sleep_q <= !stop_edge && !sleep_code_wr;
      end
      if (state_q == PMW_STOP && state_d == PMW_WAKE) begin
        from_sleep_q <= 1'b0;
      end else if (state_q == PMW_SLEEP && state_d == PMW_PWR_UP) begin
        from_sleep_q <= 1'b1;
      end
    end
  end

  // Once woken from sleep the core keeps the external clock
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ext_clk_q <= 1'b0;
    end else if (cold_rst) begin
      ext_clk_q <= 1'b0;
    end else if (state_q == PMW_SLEEP && state_d == PMW_PWR_UP) begin
      ext_clk_q <= 1'b1;
    end
  end

  // Field views of the two wait registers, main pll first
  assign settle_val[0] = settle_wait_q[`PMW_SETTLE_MAIN_MSB:`PMW_SETTLE_MAIN_LSB];
  assign settle_val[1] = settle_wait_q[`PMW_SETTLE_USB_MSB:`PMW_SETTLE_USB_LSB];
  assign lock_val[0]   = lock_count_q[`PMW_LOCK_MAIN_MSB:`PMW_LOCK_MAIN_LSB];
  assign lock_val[1]   = lock_count_q[`PMW_LOCK_USB_MSB:`PMW_LOCK_USB_LSB];

  // Per-pll settle then lock wait, counted in reference periods
  for (genvar p = 0; p < 2; p++) begin : g_pll
    logic [`PMW_CNT_W-1:0] cnt_q;
    logic                  lock_ph_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        cnt_q        <= '0;
        lock_ph_q    <= 1'b0;
        pll_rdy_q[p] <= 1'b1;
      end else if (cold_rst) begin
        cnt_q        <= '0;
        lock_ph_q    <= 1'b0;
        pll_rdy_q[p] <= 1'b1;
      end else if (pll_off) begin
        pll_rdy_q[p] <= 1'b0;
        if (wake_start) begin
          cnt_q     <= settle_val[p];
          lock_ph_q <= 1'b0;
        end
      end else if (wake_start) begin
        cnt_q        <= settle_val[p];
        lock_ph_q    <= 1'b0;
        pll_rdy_q[p] <= 1'b0;
      end else if (!pll_rdy_q[p]) begin
        if (cnt_q != '0) begin
          cnt_q <= cnt_q - 1'b1;
        end else if (!lock_ph_q) begin
          lock_ph_q <= 1'b1;
          cnt_q     <= {lock_val[p], `PMW_LOCK_SHIFT_ZERO};
        end else begin
          pll_rdy_q[p] <= 1'b1;
        end
      end
    end
  end

  // Read mux; unmapped and write-only fields read as zero
  always_comb begin
    rd_mux = '0;
    case (avs_address)
      `PMW_ADDR_LOCK_COUNT:  rd_mux = lock_count_q;
      `PMW_ADDR_SETTLE_WAIT: rd_mux = settle_wait_q;
      `PMW_ADDR_CLOCK_GATE:  rd_mux = clock_gate_q;
      `PMW_ADDR_POWER_MGMT:  rd_mux[`PMW_PM_BATT_MSB:`PMW_PM_BATT_LSB] = batt_mode_q;
      `PMW_ADDR_STATUS: begin
        rd_mux[`PMW_ST_MODE_MSB:`PMW_ST_MODE_LSB] = state_q;
        rd_mux[`PMW_ST_BATT_SLEEP_BIT]            = batt_sleep_q;
        rd_mux[`PMW_ST_MAIN_RDY_BIT]              = pll_rdy_q[0];
        rd_mux[`PMW_ST_USB_RDY_BIT]               = pll_rdy_q[1];
      end
      default: rd_mux = '0;
    endcase
  end

  // Wait-time registers survive warm, soft and sleep resets
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lock_count_q  <= `PMW_RST_LOCK_COUNT;
      settle_wait_q <= `PMW_RST_SETTLE_WAIT;
    end else if (cold_rst) begin
      lock_count_q  <= `PMW_RST_LOCK_COUNT;
      settle_wait_q <= `PMW_RST_SETTLE_WAIT;
    end else if (wr_take) begin
      if (avs_address == `PMW_ADDR_LOCK_COUNT) begin
        lock_count_q <= wr_lock & `PMW_RST_LOCK_COUNT;
      end
      if (avs_address == `PMW_ADDR_SETTLE_WAIT) begin
        settle_wait_q <= wr_settle;
      end
    end
  end

  // Clock gate and power management: reinitialised after sleep like power-on
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clock_gate_q <= `PMW_RST_CLOCK_GATE;
      batt_mode_q  <= 2'(`PMW_RST_POWER_MGMT >> `PMW_PM_BATT_LSB);
    end else if (cold_rst || (state_q == PMW_SLEEP && state_d == PMW_PWR_UP)) begin
      clock_gate_q <= `PMW_RST_CLOCK_GATE;
      batt_mode_q  <= 2'(`PMW_RST_POWER_MGMT >> `PMW_PM_BATT_LSB);
    end else if (wr_take) begin
      if (avs_address == `PMW_ADDR_CLOCK_GATE) begin
        clock_gate_q <= wr_gate;
      end
      if (avs_address == `PMW_ADDR_POWER_MGMT && avs_byteenable[1]) begin
        batt_mode_q <= wr_pm[`PMW_PM_BATT_MSB:`PMW_PM_BATT_LSB];
      end
    end
  end

  // Previous mode-bit values; bits stay set until software clears them
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idle_prev_q <= 1'b0;
      stop_prev_q <= 1'b0;
    end else begin
      idle_prev_q <= clock_gate_q[`PMW_CG_IDLE_BIT];
      stop_prev_q <= clock_gate_q[`PMW_CG_STOP_BIT];
    end
  end

  // Soft reset is a write-one pulse; it never reads back
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_take && (avs_address == `PMW_ADDR_POWER_MGMT)
                    && wr_pm[`PMW_PM_SOFT_RST_BIT];
    end
  end

  // Registered outputs, derived from the next state so they change with it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
      sdram_sr_req    <= 1'b0;
      clk_ctl         <= '{xtal_en: 1'b1, main_pll_en: 1'b1, usb_pll_en: 1'b1,
                           core_clock_en: 1'b1, core_clock_ext: 1'b0};
      periph_clk_en   <= `PMW_PERIPH_W'(`PMW_RST_CLOCK_GATE >> `PMW_CG_PERIPH_LSB);
      regulator_off_n <= 1'b1;
      sys_reset_n     <= 1'b0;
      fast_irq        <= 1'b0;
    end else begin
      // Waitrequest drops for exactly one cycle per request, so back-to-back accesses cost two cycles
      avs_waitrequest <= !(avs_waitrequest && bus_req);
      avs_readdata    <= rd_start ? rd_mux : avs_readdata;  // Held until the next read
      // Self-refresh held from entry until the wake sequence ends
      sdram_sr_req <= (state_d != PMW_NORMAL) && (state_d != PMW_IDLE);
      // Oscillator and plls stop only once self-refresh is acknowledged
      clk_ctl.xtal_en     <= (state_d != PMW_STOP) && (state_d != PMW_SLEEP);
      clk_ctl.main_pll_en <= (state_d != PMW_STOP) && (state_d != PMW_SLEEP);
      clk_ctl.usb_pll_en  <= (state_d != PMW_STOP) && (state_d != PMW_SLEEP);
      // Core clock: stopped in idle, stop and sleep; during waits only after sleep
      case (state_d)
        PMW_NORMAL, PMW_SR_WAIT: clk_ctl.core_clock_en <= 1'b1;
        PMW_WAKE:                clk_ctl.core_clock_en <= from_sleep_q;
        default:                 clk_ctl.core_clock_en <= 1'b0;
      endcase
      clk_ctl.core_clock_ext <= ext_clk_q || (state_q == PMW_SLEEP && state_d == PMW_PWR_UP);
      // Peripheral gates follow their enable bits in normal and idle mode only
      periph_clk_en <= (state_d == PMW_NORMAL || state_d == PMW_IDLE)
                       ? clock_gate_q[`PMW_CG_PERIPH_MSB:`PMW_CG_PERIPH_LSB] : '0;
      // Regulator is off in sleep and is released on wake in the same cycle as oscillator and plls
      regulator_off_n <= (state_d != PMW_SLEEP);
      // System reset scope: warm, soft, cold and sleep wake; this block is spared
      sys_reset_n <= warm_reset_n && !soft_rst_q && !cold_rst
                     && (state_d != PMW_PWR_UP) && !(state_d == PMW_WAKE && from_sleep_q);
      fast_irq    <= (batt_mode_q == PMW_BATT_FIQ) && !battery_fault_n;
    end
  end

endmodule : pmw_power_ctrl

`default_nettype wire

// ### verilog/pmw_params.svh
// Constants of the power-mode and wake-up controller: register byte
// addresses, field positions, reset values and wait-timing figures.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PMW_PARAMS_SVH
`define PMW_PARAMS_SVH

// Register byte addresses on the Avalon-MM bus
`define PMW_ADDR_LOCK_COUNT   32'h4000_0000
`define PMW_ADDR_SETTLE_WAIT  32'h4000_0004
`define PMW_ADDR_CLOCK_GATE   32'h4000_0020
`define PMW_ADDR_POWER_MGMT   32'h4000_0030
`define PMW_ADDR_STATUS       32'h4000_0034

// Reset values
`define PMW_RST_LOCK_COUNT    32'h0fff_0fff
`define PMW_RST_SETTLE_WAIT   32'h5000_5000
`define PMW_RST_CLOCK_GATE    32'h03ff_fff0
`define PMW_RST_POWER_MGMT    32'h0000_0000

// Lock count fields (main pll in the low half, usb pll in the high half)
`define PMW_LOCK_MAIN_MSB     11
`define PMW_LOCK_MAIN_LSB     0
`define PMW_LOCK_USB_MSB      27
`define PMW_LOCK_USB_LSB      16
`define PMW_LOCK_W            12
// Settle count fields
`define PMW_SETTLE_MAIN_MSB   15
`define PMW_SETTLE_MAIN_LSB   0
`define PMW_SETTLE_USB_MSB    31
`define PMW_SETTLE_USB_LSB    16
`define PMW_CNT_W             16
// Lock wait is the count times 16 reference periods: a 4-bit shift
`define PMW_LOCK_SHIFT_ZERO   4'h0

// Clock gate control fields
`define PMW_CG_STOP_BIT       0
`define PMW_CG_IDLE_BIT       2
`define PMW_CG_PERIPH_MSB     29
`define PMW_CG_PERIPH_LSB     4
`define PMW_PERIPH_W          26

// Power management register fields
`define PMW_PM_CODE_MSB       7
`define PMW_PM_CODE_LSB       0
`define PMW_PM_BATT_MSB       9
`define PMW_PM_BATT_LSB       8
`define PMW_PM_SOFT_RST_BIT   16
`define PMW_SLEEP_CODE        8'ha3

// Status register fields
`define PMW_ST_MODE_MSB       2
`define PMW_ST_MODE_LSB       0
`define PMW_ST_BATT_SLEEP_BIT 3
`define PMW_ST_MAIN_RDY_BIT   4
`define PMW_ST_USB_RDY_BIT    5

`endif

// ### verilog/pmw_pkg.sv
// Types of the power-mode and wake-up controller.
// Assumes pmw_params.svh on the include path.
package pmw_pkg;
  `include "pmw_params.svh"

  // Power-mode sequencer states
  typedef enum logic [2:0] {
    PMW_NORMAL  = 3'b000,
    PMW_IDLE    = 3'b001,
    PMW_SR_WAIT = 3'b010,
    PMW_STOP    = 3'b011,
    PMW_SLEEP   = 3'b100,
    PMW_PWR_UP  = 3'b101,
    PMW_WAKE    = 3'b110
  } pmw_state_t;

  // Handling of a low battery fault input
  typedef enum logic [1:0] {
    PMW_BATT_IGNORE = 2'b00,
    PMW_BATT_FIQ    = 2'b01,
    PMW_BATT_SLEEP  = 2'b10
  } pmw_batt_mode_t;

  // Wake-up event lines
  typedef struct packed {
    logic [9:0] ext_int;
    logic       alarm_int;
    logic       pen_down_int;
    logic       modem_int;
  } pmw_wake_t;

  // Clock and oscillator controls towards the clock tree
  typedef struct packed {
    logic xtal_en;
    logic main_pll_en;
    logic usb_pll_en;
    logic core_clock_en;
    logic core_clock_ext;
  } pmw_clk_ctl_t;

endpackage : pmw_pkg

// ### sim/pmw_sdram_model.sv
// Self-refresh side of the sdram controller: acknowledges requests.
// Assumes the controller's reference clock and power-on reset.
`timescale 1ns/1ps
`default_nettype none
module pmw_sdram_model (
  // Clock, reset and pace
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic slow,
  // Self-refresh handshake
  input  wire logic sr_req,
  output var  logic sr_ack
);
  logic [3:0] cnt_q;
  // Ack after 2 or 7 cycles; dropped with the request, never held over
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q  <= 4'h0;
      sr_ack <= 1'b0;
    end else begin
      cnt_q  <= sr_req ? cnt_q + {3'h0, ~sr_ack} : 4'h0;
      sr_ack <= sr_req && (sr_ack || cnt_q == (slow ? 4'h6 : 4'h1));
    end
  end
endmodule : pmw_sdram_model
`default_nettype wire

// ### sim/pmw_power_ctrl_chk.sv
// Port checks of the power-mode controller.
// Assumes pmw_pkg is compiled first; bound into every controller.
`timescale 1ns/1ps
`default_nettype none
module pmw_power_ctrl_chk
  import pmw_pkg::*;
(
  // Clock and reset
  input wire logic         ref_clk,
  input wire logic         nrst,
  // Pins
  input wire logic         cold_reset_n,
  input wire logic         warm_reset_n,
  input wire logic         battery_fault_n,
  input wire logic         sdram_sr_ack,
  // Outputs watched
  input wire logic         sdram_sr_req,
  input wire pmw_clk_ctl_t clk_ctl,
  input wire logic [25:0]  periph_clk_en,
  input wire logic         regulator_off_n,
  input wire logic         sys_reset_n
);
  // One clock domain, so one clocking and one disable
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Entry order, clocks dark while stopped, release only with core clock on
  sr_first_a: assert property ($fell(clk_ctl.xtal_en) |-> sdram_sr_req && $past(sdram_sr_ack))
    else $error("oscillator stopped without self-refresh ack");
  supply_off_a: assert property ($fell(regulator_off_n) |-> !clk_ctl.xtal_en && !clk_ctl.main_pll_en)
    else $error("supply cut while clocks still run");
  dark_gates_a: assert property (!clk_ctl.xtal_en |-> periph_clk_en == '0 && !clk_ctl.core_clock_en)
    else $error("clock given while oscillator is off");
  sr_release_a: assert property ($fell(sdram_sr_req) |-> clk_ctl.core_clock_en && clk_ctl.xtal_en)
    else $error("self-refresh left before clocks returned");
  // Wake sequences
  stop_dark_a: assert property ($rose(clk_ctl.main_pll_en) && !clk_ctl.core_clock_ext && $past(cold_reset_n)
    |-> !clk_ctl.core_clock_en [*2])
    else $error("core clock given during lock wait");
  sleep_wake_a: assert property ($rose(regulator_off_n) && $past(cold_reset_n)
    |-> !sys_reset_n && clk_ctl.core_clock_ext)
    else $error("sleep wake not in reset on external clock");
  // Reset scope
  cold_init_a: assert property (!$past(cold_reset_n) && !cold_reset_n && $past(battery_fault_n) && battery_fault_n
    |-> !sys_reset_n && regulator_off_n && !sdram_sr_req)
    else $error("cold reset did not initialise");
  warm_reset_a: assert property (!$past(warm_reset_n) && !warm_reset_n |-> !sys_reset_n)
    else $error("warm reset did not reach system reset");
endmodule : pmw_power_ctrl_chk
bind pmw_power_ctrl pmw_power_ctrl_chk u_chk (.ref_clk, .nrst, .cold_reset_n, .warm_reset_n, .battery_fault_n,
  .sdram_sr_ack, .sdram_sr_req, .clk_ctl, .periph_clk_en, .regulator_off_n, .sys_reset_n);
`default_nettype wire

// ### sim/pmw_power_ctrl_tb.sv
// Self-checking bench of the power-mode controller, random gate data.
// Assumes checker and self-refresh model compiled before it.
`timescale 1ns/1ps
`default_nettype none
module pmw_power_ctrl_tb;
  import pmw_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, slow = 1'b0;
  logic cold_reset_n = 1'b1, warm_reset_n = 1'b1, battery_fault_n = 1'b1;
  logic avs_waitrequest, sdram_sr_req, sdram_sr_ack, regulator_off_n, sys_reset_n, fast_irq;
  logic [31:0] avs_address = '0, avs_writedata = '0, avs_readdata, q, cgv, rnd = 32'h12b2_d74e;
  logic [25:0] periph_clk_en;
  pmw_wake_t wake_src = '0;
  pmw_clk_ctl_t clk_ctl;
  int error_cnt = 0, n_tests = 0, cyc = 0, n, e;
  always #12.5 ref_clk = ~ref_clk;
  pmw_power_ctrl u_dut (.ref_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .cold_reset_n, .warm_reset_n,
    .battery_fault_n, .wake_src, .sdram_sr_req, .sdram_sr_ack, .clk_ctl, .periph_clk_en,
    .regulator_off_n, .sys_reset_n, .fast_irq);
  pmw_sdram_model u_sr (.ref_clk, .nrst, .slow, .sr_req(sdram_sr_req), .sr_ack(sdram_sr_ack));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Wake length: settle count, then lock count times 16
  function automatic int wake_len(input int s, input int l);
    return s + l * 16;
  endfunction : wake_len
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] x);
    bus(1'b0, a, '0);
    chk(q & m, x);
  endtask : rd
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : tick
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // Hang guard, far above the short waits programmed here
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 40000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  initial begin
    tick(3);
    nrst <= 1'b1;
    // Reset values, lock field masking, unmapped hole
    rd(32'h4000_0000, '1, 32'h0fff_0fff);
    rd(32'h4000_0004, '1, 32'h5000_5000);
    rd(32'h4000_0008, '1, '0);
    bus(1'b1, 32'h4000_0000, '1);
    rd(32'h4000_0000, '1, 32'h0fff_0fff);
    $display("test registers done");
    // Idle ended by each interrupt line and by warm reset in turn; bit left set must not retrigger
    for (int k = 0; k < 14; k++) begin
      bus(1'b1, 32'h4000_0020, 32'h03ff_fff4);
      tick(2);
      rd(32'h4000_0034, 32'h7, 32'h1);
      chk(clk_ctl.main_pll_en, 1'b1);
      if (k < 13) wake_src <= pmw_wake_t'(13'h1 << k);
      else warm_reset_n <= 1'b0;
      tick(2);
      wake_src     <= '0;
      warm_reset_n <= 1'b1;
      repeat (200) if (clk_ctl.core_clock_en !== 1'b1 || sys_reset_n !== 1'b1) @(posedge ref_clk);
      rd(32'h4000_0034, 32'h7, 32'h0);
      bus(1'b1, 32'h4000_0020, 32'h03ff_fff0);
    end
    $display("test idle done");
    // Stop with short random waits, reloaded at each wake
    for (int it = 0; it < 2; it++) begin
      rnd  = lfsr(rnd);
      slow <= it[0];
      cgv  = rnd & 32'h37ff_ffd0;
      e    = wake_len(1 + rnd[2:0], 1 + rnd[5:4]);
      bus(1'b1, 32'h4000_0000, {2{16'(1 + rnd[5:4])}});
      bus(1'b1, 32'h4000_0004, {2{16'(1 + rnd[2:0])}});
      bus(1'b1, 32'h4000_0020, cgv);
      tick(2);
      chk(32'(periph_clk_en), 32'(cgv[29:4]));
      bus(1'b1, 32'h4000_0020, cgv | 32'h1);
      repeat (100) if (clk_ctl.xtal_en !== 1'b0) @(posedge ref_clk);
      chk({sdram_sr_req, clk_ctl.xtal_en}, 2'b10);
      tick(4);
      wake_src <= it ? 13'h0008 : 13'h0001;
      repeat (100) if (clk_ctl.main_pll_en !== 1'b1) @(posedge ref_clk);
      wake_src <= '0;
      n = 0;
      while (clk_ctl.core_clock_en !== 1'b1 && n < 2000) begin
        @(posedge ref_clk);
        n++;
      end
      chk(32'(n >= e && n <= e + 4), 1);
      chk(clk_ctl.core_clock_ext, 1'b0);
      rd(32'h4000_0020, '1, cgv | 32'h1);
      bus(1'b1, 32'h4000_0020, cgv);
    end
    $display("test stop done");
    // Wrong code refused; coded sleep ignores pen-down and modem
    bus(1'b1, 32'h4000_0030, 32'h0000_005a);
    tick(2);
    rd(32'h4000_0034, 32'h7, 32'h0);
    bus(1'b1, 32'h4000_0030, 32'h0000_00a3);
    repeat (100) if (regulator_off_n !== 1'b0) @(posedge ref_clk);
    wake_src <= 13'h0003;
    tick(4);
    chk(regulator_off_n, 1'b0);
    wake_src <= 13'h0004;
    repeat (100) if (regulator_off_n !== 1'b1) @(posedge ref_clk);
    chk({sys_reset_n, clk_ctl.core_clock_ext}, 2'b01);
    wake_src <= '0;
    repeat (3000) if (sdram_sr_req !== 1'b0) @(posedge ref_clk);
    tick(2);
    chk(clk_ctl.core_clock_ext, 1'b1);
    rd(32'h4000_0020, '1, 32'h03ff_fff0);
    $display("test sleep done");
    // Battery fault: fast irq, ignored with cold reset masked, then sleep
    bus(1'b1, 32'h4000_0030, 32'h0000_0100);
    battery_fault_n <= 1'b0;
    tick(3);
    chk(fast_irq, 1'b1);
    bus(1'b1, 32'h4000_0030, 32'h0000_0000);
    bus(1'b1, 32'h4000_0000, 32'h0005_0007);
    cold_reset_n <= 1'b0;
    tick(3);
    cold_reset_n <= 1'b1;
    chk({fast_irq, sys_reset_n}, 2'b01);
    rd(32'h4000_0000, '1, 32'h0005_0007);
    bus(1'b1, 32'h4000_0030, 32'h0000_0200);
    repeat (100) if (regulator_off_n !== 1'b0) @(posedge ref_clk);
    wake_src <= 13'h0020;
    tick(4);
    chk(regulator_off_n, 1'b0);
    wake_src        <= 13'h0010;
    battery_fault_n <= 1'b1;
    repeat (100) if (regulator_off_n !== 1'b1) @(posedge ref_clk);
    chk(regulator_off_n, 1'b1);
    wake_src <= '0;
    repeat (3000) if (sdram_sr_req !== 1'b0) @(posedge ref_clk);
    rd(32'h4000_0034, 32'h3f, 32'h38);
    $display("test battery done");
    // Warm and soft reset spare the lock count register, cold reset restores its reset value
    bus(1'b1, 32'h4000_0000, 32'h0005_0007);
    warm_reset_n <= 1'b0;
    tick(3);
    warm_reset_n <= 1'b1;
    chk(sys_reset_n, 1'b0);
    tick(2);
    bus(1'b1, 32'h4000_0030, 32'h0001_0000);
    tick(2);
    chk(sys_reset_n, 1'b0);
    rd(32'h4000_0000, '1, 32'h0005_0007);
    cold_reset_n <= 1'b0;
    tick(3);
    cold_reset_n <= 1'b1;
    tick(2);
    rd(32'h4000_0000, '1, 32'h0fff_0fff);
    $display("test resets done");
    tally_and_finish;
  end
endmodule : pmw_power_ctrl_tb
`default_nettype wire
